// ==== bench/flash_cmd_seq_sva.sv ====
/*
  Checker of the flash command handler: busy timing, pulses, read-only bits.
  Assumes it is bound to flash_cmd_seq and sees only its ports.
*/
`default_nettype none

module flash_cmd_seq_sva #(
  parameter int unsigned SRWR_CYCLES = 20,
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       cs_n,
  input wire logic       so,
  input wire logic [7:0] status_reg_one,
  input wire logic [7:0] status_reg_two,
  input wire logic [7:0] status_reg_three,
  input wire logic       nv_wr_strobe,
  input wire logic [7:0] nv_wr_sr1,
  input wire logic [7:0] nv_wr_sr2,
  input wire logic       prog_start
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] busy_cnt_reg;
  logic        busy_d_reg;
  logic        prog_kind_reg;

  always_ff @(posedge mclk) begin
    if (!nrst || !status_reg_one[0]) busy_cnt_reg <= 32'h0000_0000;
    else busy_cnt_reg <= busy_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) busy_d_reg <= 1'b0;
    else busy_d_reg <= status_reg_one[0];
  end

  // remembers what started the busy run, nothing else tells it apart
  always_ff @(posedge mclk) begin
    if (!nrst) prog_kind_reg <= 1'b0;
    else if (prog_start) prog_kind_reg <= 1'b1;
    else if (busy_d_reg && !status_reg_one[0]) prog_kind_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_busy_up;
    ##[1:2] status_reg_one[0];
  endsequence

  sequence s_busy_end;
    $fell(status_reg_one[0]);
  endsequence

  AST_PROG_TIME: assert property (s_busy_end and prog_kind_reg |->
    busy_cnt_reg >= PROG_CYCLES - 1 && busy_cnt_reg <= PROG_CYCLES + 1 && !status_reg_one[1])
    else $error("program busy length or latch wrong");
  AST_SRWR_TIME: assert property (s_busy_end and !prog_kind_reg |->
    busy_cnt_reg >= SRWR_CYCLES - 1 && busy_cnt_reg <= SRWR_CYCLES + 1)
    else $error("status write busy length wrong");
  AST_STROBE_END: assert property (nv_wr_strobe |-> ##[1:2] status_reg_one[1:0] == 2'b00)
    else $error("latch or busy still set after status write");
  AST_STROBE_BUSY: assert property (nv_wr_strobe |-> $past(status_reg_one[0]))
    else $error("status write stored without busy run");
  AST_BUSY_UP: assert property (prog_start |-> s_busy_up)
    else $error("busy not raised by program");
  AST_PROG_IDLE: assert property (prog_start |-> status_reg_one[1:0] == 2'b10)
    else $error("program accepted without latch or while busy");
  AST_PULSES: assert property ((prog_start || nv_wr_strobe) |=> !(prog_start || nv_wr_strobe))
    else $error("start pulse longer than one cycle");
  AST_NV_FIELDS: assert property (nv_wr_strobe |-> nv_wr_sr1[1:0] == 2'b00 && !nv_wr_sr2[7])
    else $error("read-only bit in stored status");
  AST_RO_BITS: assert property (!status_reg_two[7] && !status_reg_three[7])
    else $error("read-only status bit set");
  AST_LOCK_OTP: assert property (($past(status_reg_two[5:2]) & ~status_reg_two[5:2]) == 4'h0)
    else $error("security lock bit returned to zero");
  AST_SO_QUIET: assert property (cs_n |-> !so)
    else $error("serial out active while deselected");
endmodule // flash_cmd_seq_sva

bind flash_cmd_seq flash_cmd_seq_sva #(
  .SRWR_CYCLES(SRWR_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)
) i_sva (
  .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .so(so), .status_reg_one(status_reg_one),
  .status_reg_two(status_reg_two), .status_reg_three(status_reg_three),
  .nv_wr_strobe(nv_wr_strobe), .nv_wr_sr1(nv_wr_sr1), .nv_wr_sr2(nv_wr_sr2),
  .prog_start(prog_start)
);

`default_nettype wire

// ==== bench/spi_host_model.sv ====
/*
  Serial host model: mode 0 frames at a 48 ns link clock.
  Assumes the caller spaces frames; the link clock stands still between them.
*/
`default_nettype none

module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // sends nb bits of d from bit 47 down, collecting so at each rise
  task automatic xfer(input logic [47:0] d, input int nb, output logic [15:0] rx);
    rx   = 16'h0000;
    cs_n = 1'b0;
    #30;
    for (int i = 0; i < nb; i++) begin
      si = d[47 - i];
      #24 sclk = 1'b1;
      rx = {rx[14:0], so};
      #24 sclk = 1'b0;
    end
    #30 cs_n = 1'b1;
    // released line must not keep looking valid
    si = ~si;
    #60;
  endtask
endmodule // spi_host_model

`default_nettype wire

// ==== bench/tb_spi_flash_status_and_page_program.sv ====
/*
  Testbench of the flash command handler: serial frames through the host model,
  status outputs and program outputs compared with expected values.
  Assumes short busy counts set at the instance.
*/
`default_nettype none

module tb_spi_flash_status_and_page_program;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, nrst, sclk, cs_n, si, so, nv_wr_strobe, prog_start;
  logic [7:0]  nv_sr1_in, nv_sr2_in, page_rd_idx, page_rd_data;
  logic [7:0]  status_reg_one, status_reg_two, status_reg_three, nv_wr_sr1, nv_wr_sr2;
  logic [23:0] prog_addr;
  logic [15:0] rx;
  int          mismatches, total_checks, prog_cnt, strobe_cnt;
  logic [7:0]  ops  [3] = '{8'h05, 8'h35, 8'h33};
  logic [7:0]  exps [3] = '{8'h80, 8'h08, 8'h00};

  flash_cmd_seq #(.SRWR_CYCLES(600), .PROG_CYCLES(600)) i_dut (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .nv_sr1_in(nv_sr1_in), .nv_sr2_in(nv_sr2_in), .page_rd_idx(page_rd_idx), .so(so),
    .status_reg_one(status_reg_one), .status_reg_two(status_reg_two),
    .status_reg_three(status_reg_three), .nv_wr_strobe(nv_wr_strobe),
    .nv_wr_sr1(nv_wr_sr1), .nv_wr_sr2(nv_wr_sr2), .prog_start(prog_start),
    .prog_addr(prog_addr), .page_rd_data(page_rd_data));

  spi_host_model i_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (prog_start === 1'b1) prog_cnt++;
    if (nv_wr_strobe === 1'b1) strobe_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [47:0] d, input int nb);
    i_host.xfer(d, nb, rx);
    repeat (8) @(negedge mclk);
  endtask

  task automatic wait_idle;
    for (int k = 0; k < 1000 && status_reg_one[0] !== 1'b0; k++) @(negedge mclk);
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #300000;
    mismatches++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    nv_sr1_in = 8'h83;
    nv_sr2_in = 8'h08;
    page_rd_idx = 8'h00;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    check(status_reg_one, 8'h80);
    check(status_reg_two, 8'h08);
    check(status_reg_three, 8'h00);
    for (int k = 0; k < 3; k++) begin
      cmd({ops[k], 40'h00_0000_0000}, 24);
      check(rx[15:8], exps[k]);
      check(rx[7:0], exps[k]);
    end
    cmd(48'h0600_0000_0000, 8);
    check(status_reg_one, 8'h82);
    cmd(48'h0400_0000_0000, 8);
    check(status_reg_one, 8'h80);
    cmd(48'h0100_0000_0000, 24);
    check(status_reg_one, 8'h80);
    cmd(48'h5000_0000_0000, 8);
    cmd(48'h0500_0000_0000, 16);
    cmd(48'h0100_0000_0000, 16);
    check(status_reg_one, 8'h80);
    cmd(48'h5000_0000_0000, 8);
    cmd(48'h0103_7f55_0000, 32);
    check(status_reg_one, 8'h00);
    check(status_reg_two, 8'h4a);
    check(status_reg_three, 8'h55);
    check(strobe_cnt, 0);
    cmd(48'h5000_0000_0000, 8);
    cmd(48'h0100_0000_0000, 12);
    check(status_reg_two, 8'h4a);
    cmd(48'h5000_0000_0000, 8);
    cmd(48'h0100_0000_0000, 16);
    check(status_reg_two, 8'h08);
    check(status_reg_three, 8'h55);
    cmd(48'h0600_0000_0000, 8);
    cmd(48'h0100_1000_0000, 24);
    check(status_reg_one[0], 1'b1);
    cmd(48'h0400_0000_0000, 8);
    check(status_reg_one, 8'h03);
    cmd(48'h0500_0000_0000, 16);
    check(rx[7:0], 8'h03);
    wait_idle();
    check(strobe_cnt, 1);
    check(nv_wr_sr2, 8'h18);
    check(nv_wr_sr1, 8'h00);
    check(status_reg_one, 8'h00);
    cmd(48'h5000_0000_0000, 8);
    cmd(48'h0100_0000_0000, 24);
    check(status_reg_two, 8'h18);
    cmd(48'h0200_12ff_a1b2, 48);
    check(prog_cnt, 0);
    cmd(48'h0600_0000_0000, 8);
    cmd(48'h0200_12ff_a1b2, 44);
    check(prog_cnt, 0);
    cmd(48'h0200_12ff_a1b2, 48);
    check(prog_cnt, 1);
    check(prog_addr, 24'h00_12ff);
    page_rd_idx = 8'h00;
    repeat (2) @(negedge mclk);
    check(page_rd_data, 8'hb2);
    page_rd_idx = 8'hff;
    repeat (2) @(negedge mclk);
    check(page_rd_data, 8'ha1);
    wait_idle();
    check(status_reg_one, 8'h00);
    cmd(48'h5000_0000_0000, 8);
    cmd(48'h011c_0000_0000, 16);
    check(status_reg_one, 8'h1c);
    cmd(48'h0600_0000_0000, 8);
    cmd(48'h0200_12ff_a1b2, 48);
    check(prog_cnt, 1);
    print_verdict();
  end
endmodule // tb_spi_flash_status_and_page_program

`default_nettype wire

// ==== rtl/flash_cmd_pkg.sv ====
/*
  Types of the flash status and page-program command handler.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package flash_cmd_pkg;

  typedef logic [7:0] byte_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SRWR = 3'b010,
    ST_PROG = 3'b100
  } seq_state_type;

endpackage

`default_nettype wire

// ==== rtl/flash_cmd_regs.svh ====
/*
  Constants of the flash status and page-program command handler:
  opcodes, status bit positions and masks, reset values, timing figures.
  Assumes inclusion by bare name from the rtl directory.
*/
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

`define OP_READ_ST1    8'h05
`define OP_READ_ST2    8'h35
`define OP_READ_ST3    8'h33
`define OP_LATCH_SET   8'h06
`define OP_LATCH_CLR   8'h04
`define OP_VOL_ENABLE  8'h50
`define OP_STATUS_WR   8'h01
`define OP_PAGE_PROG   8'h02

`define STAT1_BUSY       0
`define STAT1_LATCH      1
`define STAT1_BP_LSB     2
`define STAT1_TOP_BOT    5
`define STAT1_SECTOR     6
`define STAT2_LOCK1      0
`define STAT2_COMPL      6
`define STAT2_CQ_MASK    7'h42
`define STAT2_LB_MASK    7'h3c
`define STAT2_VOL_KEEP   7'h3d
`define STAT3_RESET      7'h00

`define PP_MIN_BYTES   9'h005
`define CLK_PERIOD_NS  10
`define STATUS_WRITE_TIME_US 10000
`define PAGE_PROGRAM_TIME_US 700

`endif

// ==== rtl/flash_cmd_seq.sv ====
/*
  Command handler of a serial flash: status reads, write-enable latch,
  status writes (volatile and non-volatile) and page program with busy.
  Assumes sclk (mode 0/3) is quiet while cs_n is high, cs_n low edges come
  at least 30 ns before the first sclk rise and rise 30 ns after the last.
*/
`default_nettype none

`include "flash_cmd_regs.svh"

module flash_cmd_seq
  import flash_cmd_pkg::*;
#(
  parameter int unsigned SRWR_CYCLES =
    `STATUS_WRITE_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned PROG_CYCLES =
    `PAGE_PROGRAM_TIME_US * 1000 / `CLK_PERIOD_NS
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic [7:0]  nv_sr1_in,
  input  wire logic [7:0]  nv_sr2_in,
  input  wire logic [7:0]  page_rd_idx,
  output logic             so,
  output logic [7:0]       status_reg_one,
  output logic [7:0]       status_reg_two,
  output logic [7:0]       status_reg_three,
  output logic             nv_wr_strobe,
  output logic [7:0]       nv_wr_sr1,
  output logic [7:0]       nv_wr_sr2,
  output logic             prog_start,
  output logic [23:0]      prog_addr,
  output logic [7:0]       page_rd_data
);

  localparam logic [23:0] SRWR_LOAD = 24'(SRWR_CYCLES - 1);
  localparam logic [23:0] PROG_LOAD = 24'(PROG_CYCLES - 1);

  ////////////////////////////////////////
  // link side, on sclk

  logic [2:0]  bit_cnt_reg;
  logic [6:0]  rx_shift_reg;
  byte_type    byte_hold_reg;
  logic        bit_tgl_reg;
  logic        byte_tgl_reg;
  logic        first_done_reg;
  logic [1:0]  rd_sel_reg;
  byte_type    tx_shift_reg;
  logic [23:0] stat_meta_reg;
  logic [23:0] stat_sync_reg;
  byte_type    rx_byte;

  assign rx_byte = {rx_shift_reg, si};

  // frame-scoped state dies with cs_n, the clock may stop right after
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg  <= 3'd0;
      rx_shift_reg <= 7'h00;
    end else begin
      bit_cnt_reg  <= bit_cnt_reg + 3'd1;
      rx_shift_reg <= rx_byte[6:0];
    end
  end

  // toggles must survive frames, else a reset would look like an event
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      bit_tgl_reg   <= 1'b0;
      byte_tgl_reg  <= 1'b0;
      byte_hold_reg <= 8'h00;
    end else begin
      bit_tgl_reg <= ~bit_tgl_reg;
      if (bit_cnt_reg == 3'd7) begin
        byte_hold_reg <= rx_byte;
        byte_tgl_reg  <= ~byte_tgl_reg;
      end
    end
  end

  // per-bit level sync; bits settle during the 8-clock opcode
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      stat_meta_reg <= 24'h00_0000;
      stat_sync_reg <= 24'h00_0000;
    end else begin
      stat_meta_reg <= {status_reg_three, status_reg_two, status_reg_one};
      stat_sync_reg <= stat_meta_reg;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_done_reg <= 1'b0;
      rd_sel_reg     <= 2'd0;
    end else if (bit_cnt_reg == 3'd7 && !first_done_reg) begin
      first_done_reg <= 1'b1;
      case (rx_byte)
        `OP_READ_ST1: rd_sel_reg <= 2'd1;
        `OP_READ_ST2: rd_sel_reg <= stat_sync_reg[`STAT1_BUSY] ? 2'd0 : 2'd2;
        `OP_READ_ST3: rd_sel_reg <= stat_sync_reg[`STAT1_BUSY] ? 2'd0 : 2'd3;
        default:      rd_sel_reg <= 2'd0;
      endcase
    end
  end

  // loads on the falling edge that opens each byte after the opcode
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_shift_reg <= 8'h00;
    end else if (bit_cnt_reg == 3'd0 && first_done_reg) begin
      case (rd_sel_reg)
        2'd1:    tx_shift_reg <= stat_sync_reg[7:0];
        2'd2:    tx_shift_reg <= stat_sync_reg[15:8];
        2'd3:    tx_shift_reg <= stat_sync_reg[23:16];
        default: tx_shift_reg <= 8'h00;
      endcase
    end else begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  assign so = tx_shift_reg[7];

  ////////////////////////////////////////
  // crossings into mclk

  logic [1:0] cs_sync_reg;
  logic       cs_prev_reg;
  logic [1:0] bit_sync_reg;
  logic       bit_prev_reg;
  logic [1:0] byte_sync_reg;
  logic       byte_prev_reg;
  logic       frame_start;
  logic       frame_end;
  logic       bit_ev;
  logic       byte_ev;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cs_sync_reg   <= 2'b11;
      cs_prev_reg   <= 1'b1;
      bit_sync_reg  <= 2'b00;
      bit_prev_reg  <= 1'b0;
      byte_sync_reg <= 2'b00;
      byte_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[0], cs_n};
      cs_prev_reg   <= cs_sync_reg[1];
      bit_sync_reg  <= {bit_sync_reg[0], bit_tgl_reg};
      bit_prev_reg  <= bit_sync_reg[1];
      byte_sync_reg <= {byte_sync_reg[0], byte_tgl_reg};
      byte_prev_reg <= byte_sync_reg[1];
    end
  end

  assign frame_start = cs_prev_reg & ~cs_sync_reg[1];
  assign frame_end   = ~cs_prev_reg & cs_sync_reg[1];
  assign bit_ev      = bit_sync_reg[1] ^ bit_prev_reg;
  assign byte_ev     = byte_sync_reg[1] ^ byte_prev_reg;

  ////////////////////////////////////////
  // frame capture

  seq_state_type state_reg;
  logic [2:0]    bit_phase_reg;
  logic [8:0]    byte_cnt_reg;
  byte_type      opcode_reg;
  logic [23:0]   addr_reg;
  byte_type      wr_ptr_reg;
  byte_type      sr_in1_reg;
  byte_type      sr_in2_reg;
  byte_type      sr_in3_reg;
  logic          wel_reg;
  logic          vol_pend_reg;
  logic          idle;
  logic          buf_we;
  byte_type      page_mem [256];

  assign idle = (state_reg == ST_IDLE);

  // buffer only while a program could still be taken
  assign buf_we = byte_ev && opcode_reg == `OP_PAGE_PROG && byte_cnt_reg >= 9'd4
                  && wel_reg && idle;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bit_phase_reg <= 3'd0;
      byte_cnt_reg  <= 9'd0;
      opcode_reg    <= 8'h00;
      addr_reg      <= 24'h00_0000;
      wr_ptr_reg    <= 8'h00;
      sr_in1_reg    <= 8'h00;
      sr_in2_reg    <= 8'h00;
      sr_in3_reg    <= 8'h00;
    end else if (frame_start) begin
      bit_phase_reg <= 3'd0;
      byte_cnt_reg  <= 9'd0;
    end else begin
      if (bit_ev) begin
        bit_phase_reg <= bit_phase_reg + 3'd1;
      end
      if (byte_ev) begin
        if (byte_cnt_reg != 9'h1ff) begin
          byte_cnt_reg <= byte_cnt_reg + 9'd1;
        end
        case (byte_cnt_reg)
          9'd0: opcode_reg <= byte_hold_reg;
          9'd1: begin
            addr_reg[23:16] <= byte_hold_reg;
            sr_in1_reg      <= byte_hold_reg;
          end
          9'd2: begin
            addr_reg[15:8] <= byte_hold_reg;
            sr_in2_reg     <= byte_hold_reg;
          end
          9'd3: begin
            addr_reg[7:0] <= byte_hold_reg;
            wr_ptr_reg    <= byte_hold_reg;
            sr_in3_reg    <= byte_hold_reg;
          end
          default: begin
            if (buf_we) begin
              wr_ptr_reg <= wr_ptr_reg + 8'd1;
            end
          end
        endcase
      end
    end
  end

  // later bytes land on earlier ones once the pointer wraps
  always_ff @(posedge mclk) begin
    if (buf_we) begin
      page_mem[wr_ptr_reg] <= byte_hold_reg;
    end
    page_rd_data <= page_mem[page_rd_idx];
  end

  ////////////////////////////////////////
  // command decode at frame end

  logic [5:0]  sr1_w_reg;
  logic [6:0]  sr2_w_reg;
  logic [6:0]  sr3_w_reg;
  logic [5:0]  sr1_new;
  logic [6:0]  sr2_new;
  logic [6:0]  sr3_new;
  logic        cmd_ok;
  logic        single;
  logic        do_set;
  logic        do_clr;
  logic        do_vwe;
  logic        do_srw;
  logic        do_prog;
  logic        seq_done;
  logic [23:0] timer_reg;

  // protected range, sized for 64 blocks of 64 KiB
  function automatic logic page_locked(input logic [23:0] a,
                                       input logic [5:0]  s1,
                                       input logic        cmp);
    logic [10:0] unit;
    logic [10:0] span;
    logic [10:0] total;
    logic [2:0]  bp;
    logic        sec;
    logic        hit;
    bp    = s1[`STAT1_TOP_BOT-3:`STAT1_BP_LSB-2];
    sec   = s1[`STAT1_SECTOR-2];
    unit  = sec ? {1'b0, a[21:12]} : {5'b0_0000, a[21:16]};
    total = sec ? 11'h400 : 11'h040;
    if (bp == 3'd0) begin
      span = 11'h000;
    end else if (sec && bp > 3'd4) begin
      span = 11'h008;
    end else if (!sec && bp == 3'd7) begin
      span = total;
    end else begin
      span = 11'h001 << (bp - 3'd1);
    end
    if (s1[`STAT1_TOP_BOT-2]) begin
      hit = unit < span;
    end else begin
      hit = unit >= total - span;
    end
    return hit ^ cmp;
  endfunction

  always_comb begin
    cmd_ok  = frame_end && bit_phase_reg == 3'd0 && idle;
    single  = byte_cnt_reg == 9'd1;
    do_set  = cmd_ok && single && opcode_reg == `OP_LATCH_SET;
    do_clr  = cmd_ok && single && opcode_reg == `OP_LATCH_CLR;
    do_vwe  = cmd_ok && single && opcode_reg == `OP_VOL_ENABLE;
    do_srw  = cmd_ok && opcode_reg == `OP_STATUS_WR && byte_cnt_reg >= 9'd2
              && (vol_pend_reg || wel_reg);
    do_prog = cmd_ok && opcode_reg == `OP_PAGE_PROG && byte_cnt_reg >= `PP_MIN_BYTES
              && wel_reg
              && !page_locked(addr_reg, sr1_w_reg, sr2_w_reg[`STAT2_COMPL]);
    sr1_new = sr_in1_reg[7:2];
    if (byte_cnt_reg >= 9'd3) begin
      sr2_new = sr_in2_reg[6:0];
    end else if (sr2_w_reg[`STAT2_LOCK1]) begin
      sr2_new = sr2_w_reg;
    end else begin
      sr2_new = sr2_w_reg & ~`STAT2_CQ_MASK;
    end
    if (vol_pend_reg) begin
      sr2_new = (sr2_new & ~`STAT2_VOL_KEEP) | (sr2_w_reg & `STAT2_VOL_KEEP);
    end else begin
      sr2_new = sr2_new | (sr2_w_reg & `STAT2_LB_MASK);
    end
    sr3_new = (byte_cnt_reg >= 9'd4) ? sr_in3_reg[6:0] : sr3_w_reg;
  end

  assign seq_done = !idle && timer_reg == 24'h00_0000;

  ////////////////////////////////////////
  // latch and volatile permission

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wel_reg <= 1'b0;
    end else if (seq_done) begin
      wel_reg <= 1'b0;
    end else if (do_set) begin
      wel_reg <= 1'b1;
    end else if (do_clr) begin
      wel_reg <= 1'b0;
    end
  end

  // any finished non-empty frame consumes the permission
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      vol_pend_reg <= 1'b0;
    end else if (frame_end && byte_cnt_reg != 9'd0) begin
      vol_pend_reg <= do_vwe;
    end
  end

  ////////////////////////////////////////
  // working status copy

  logic       boot_reg;
  logic [5:0] stage1_reg;
  logic [6:0] stage2_reg;
  logic [6:0] stage3_reg;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      boot_reg   <= 1'b1;
      sr1_w_reg  <= 6'h00;
      sr2_w_reg  <= 7'h00;
      sr3_w_reg  <= `STAT3_RESET;
      stage1_reg <= 6'h00;
      stage2_reg <= 7'h00;
      stage3_reg <= 7'h00;
    end else if (boot_reg) begin
      boot_reg  <= 1'b0;
      sr1_w_reg <= nv_sr1_in[7:2];
      sr2_w_reg <= nv_sr2_in[6:0];
    end else if (do_srw && vol_pend_reg) begin
      sr1_w_reg <= sr1_new;
      sr2_w_reg <= sr2_new;
      sr3_w_reg <= sr3_new;
    end else if (do_srw) begin
      stage1_reg <= sr1_new;
      stage2_reg <= sr2_new;
      stage3_reg <= sr3_new;
    end else if (seq_done && state_reg == ST_SRWR) begin
      sr1_w_reg <= stage1_reg;
      sr2_w_reg <= stage2_reg;
      sr3_w_reg <= stage3_reg;
    end
  end

  ////////////////////////////////////////
  // self-timed operations

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg    <= ST_IDLE;
      timer_reg    <= 24'h00_0000;
      prog_start   <= 1'b0;
      prog_addr    <= 24'h00_0000;
      nv_wr_strobe <= 1'b0;
      nv_wr_sr1    <= 8'h00;
      nv_wr_sr2    <= 8'h00;
    end else begin
      prog_start   <= 1'b0;
      nv_wr_strobe <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (do_srw && !vol_pend_reg) begin
            state_reg <= ST_SRWR;
            timer_reg <= SRWR_LOAD;
          end else if (do_prog) begin
            state_reg  <= ST_PROG;
            timer_reg  <= PROG_LOAD;
            prog_start <= 1'b1;
            prog_addr  <= addr_reg;
          end
        end
        ST_SRWR: begin
          if (seq_done) begin
            state_reg    <= ST_IDLE;
            nv_wr_strobe <= 1'b1;
            nv_wr_sr1    <= {stage1_reg, 2'b00};
            nv_wr_sr2    <= {1'b0, stage2_reg};
          end else begin
            timer_reg <= timer_reg - 24'd1;
          end
        end
        ST_PROG: begin
          if (seq_done) begin
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 24'd1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////
  // status outputs, one cycle behind the working copy

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      status_reg_one   <= 8'h00;
      status_reg_two   <= 8'h00;
      status_reg_three <= 8'h00;
    end else begin
      status_reg_one   <= {sr1_w_reg, wel_reg, !idle};
      status_reg_two   <= {1'b0, sr2_w_reg};
      status_reg_three <= {1'b0, sr3_w_reg};
    end
  end

endmodule // flash_cmd_seq

`default_nettype wire
